// >>> logic/drh_params.svh
// offsets, field positions and reset values of the request/handshake block
`ifndef DRH_PARAMS_SVH
`define DRH_PARAMS_SVH

// register byte offsets
`define DRH_OFF_CTRL    8'h00
`define DRH_OFF_POL     8'h04
`define DRH_OFF_MASK    8'h08
`define DRH_OFF_SWREQ   8'h0c
`define DRH_OFF_MODE    8'h10
`define DRH_OFF_STATUS  8'h14
`define DRH_OFF_CNT     8'h20
`define DRH_OFF_ADDR    8'h40
`define DRH_OFF_ARRMSK  8'he0

// field positions
`define DRH_CTRL_RUN    0
`define DRH_CTRL_M2M    1
`define DRH_MODE_WRMEM  8

// reset values, cascade channel mask and response codes
`define DRH_POL_RST     8'h00
`define DRH_MASK_RST    8'hff
`define DRH_CASCADE     8'h10
`define DRH_RESP_OKAY   2'h0
`define DRH_RESP_SLVERR 2'h2

`endif

// >>> logic/drh_pkg.sv
// types shared by the request/handshake block
package drh_pkg;

  // service sequencer states
  typedef enum logic [2:0] {
    DRH_IDLE = 3'b000,
    DRH_HOLD = 3'b001,
    DRH_S1   = 3'b010,
    DRH_S2   = 3'b011,
    DRH_S3   = 3'b100,
    DRH_S4   = 3'b101
  } drh_state_t;

  // control register fields
  typedef struct packed {
    logic mem2mem;
    logic run;
  } drh_ctrl_t;

  // winning channel from the arbiter
  typedef struct packed {
    logic       valid;
    logic [2:0] num;
  } drh_sel_t;

endpackage : drh_pkg

// >>> logic/drh_sync.sv
// two-stage synchroniser for the channel request pins
`timescale 1ns/100ps
`default_nettype none

module drh_sync (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] d,
  output var  logic [7:0] q
);

  logic [7:0] meta;

  // first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= 8'h00;
      q    <= 8'h00;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : drh_sync

`default_nettype wire

// >>> logic/drh_prio.sv
// fixed priority pick of the pending channels
`timescale 1ns/100ps
`default_nettype none

module drh_prio
  import drh_pkg::*;
(
  input  wire logic [7:0] pending,
  output var drh_sel_t    sel
);

  // lowest channel number wins
  function automatic drh_sel_t pick(input logic [7:0] p);
    drh_sel_t r;
    r = '0;
    for (int i = 7; i >= 0; i--) begin
      if (p[i]) begin
        r.valid = 1'b1;
        r.num   = 3'(i);
      end
    end
    return r;
  endfunction : pick

  assign sel = pick(pending);

endmodule : drh_prio

`default_nettype wire

// >>> logic/drh_top.sv
// request, grant and strobe logic of the dma engine with axi4-lite registers
//
// Notes on behaviour
// - memory write strobe active low, tri-stated otherwise
// - hold request on unmasked request or software request; the code also blocks software requests on masked channels
// - wait for grant before taking the bus
// - fixed priority, channel zero highest
// - requests ignored while dma clock stopped
// - request polarity programmable, reset active high
// - channels zero to three move bytes
// - channels five to seven move words
// - terminal count pulse, except channel zero memory-copy
// - memory-copy pulses terminal count on channel one
// - terminal count ends service, auto-init reloads
// - terminal count sets mask and status bit; the code leaves the mask bit unchanged on auto-init channels
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "drh_params.svh"

module drh_top
  import drh_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  chan_request,
  output var  logic [7:0]  chan_ack_n,
  output var  logic        bus_hold_request,
  input  wire logic        bus_grant_ack,
  output var  logic        dma_mem_write_n,
  output var  logic        dma_mem_write_oe_n,
  output var  logic        transfer_count_done,
  output var  logic        upper_addr_strobe_byte,
  output var  logic        upper_addr_strobe_word,
  output var  logic [7:0]  upper_addr,
  output var  logic        xfer_word
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  drh_ctrl_t   ctrl;
  logic [7:0]  pol;
  logic [7:0]  mask;
  logic [7:0]  swreq;
  logic [7:0]  autoinit;
  logic [7:0]  wrmem;
  logic [7:0]  tc_stat;
  logic [15:0] base_cnt [8];
  logic [15:0] cur_cnt  [8];
  logic [15:0] base_adr [8];
  logic [15:0] cur_adr  [8];
  drh_state_t  state;
  logic [2:0]  chan;
  logic        phase;
  logic [7:0]  req_s;
  logic        grant_s;
  logic        grant_m;
  logic [7:0]  pend;
  drh_sel_t    sel;
  logic [2:0]  ech;
  logic        at_tc;
  logic        tc_pulse;
  logic        keep_on;
  logic        swap_ph;
  logic [15:0] nxt_adr;

  // AXI bookkeeping
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_q;
  logic [31:0] w_q;
  logic [3:0]  ws_q;
  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;
  logic        do_wr;
  logic        next_bvalid;
  logic        next_rvalid;
  logic        next_aw_held;
  logic        next_w_held;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    if (a[1:0] != 2'h0) return 1'b0;
    else if (a <= `DRH_OFF_STATUS) return 1'b1;
    else if ((a & `DRH_OFF_ARRMSK) == `DRH_OFF_CNT) return 1'b1;
    else if ((a & `DRH_OFF_ARRMSK) == `DRH_OFF_ADDR) return 1'b1;
    else return 1'b0;
  endfunction : mapped

  // ---------------------------------------------------------------
  // request path
  // ---------------------------------------------------------------
  drh_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (chan_request),
    .q       (req_s)
  );

  // grant pin synchroniser, second stage read only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      grant_m <= 1'b0;
      grant_s <= 1'b0;
    end else begin
      grant_m <= bus_grant_ack;
      grant_s <= grant_m;
    end
  end

  // polarity, mask and stopped clock gate the requests
  assign pend = ctrl.run ?
                (((req_s ^ pol) | swreq) & ~mask & ~`DRH_CASCADE)
                : 8'h00;

  drh_prio u_prio (
    .pending (pend),
    .sel     (sel)
  );

  // channel on the bus: channel one in the copy's write half
  assign ech     = phase ? 3'h1 : chan;
  assign at_tc   = (cur_cnt[ech] == 16'h0000);
  assign tc_pulse = at_tc && !(ctrl.mem2mem && !phase && chan == 3'h0);
  assign swap_ph = ctrl.mem2mem && chan == 3'h0 && !phase;
  assign keep_on = !at_tc && grant_s && pend[chan];
  assign nxt_adr = cur_adr[ech] + 16'h0001;

  // ---------------------------------------------------------------
  // service sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state            <= DRH_IDLE;
      chan             <= 3'h0;
      phase            <= 1'b0;
      bus_hold_request <= 1'b0;
    end else begin
      case (state)
        DRH_IDLE: begin
          phase <= 1'b0;
          if (sel.valid) begin
            bus_hold_request <= 1'b1;
            chan             <= sel.num;
            state            <= DRH_HOLD;
          end else begin
            bus_hold_request <= 1'b0;
          end
        end
        DRH_HOLD: begin
          if (grant_s) state <= DRH_S1;
        end
        DRH_S1: state <= DRH_S2;
        DRH_S2: state <= DRH_S3;
        DRH_S3: state <= DRH_S4;
        DRH_S4: begin
          if (swap_ph) begin
            phase <= 1'b1;
            state <= (cur_adr[1][15:8] != upper_addr) ? DRH_S1 : DRH_S2;
          end else if (tc_pulse || !keep_on) begin
            phase <= 1'b0;
            state <= DRH_IDLE;
          end else begin
            phase <= 1'b0;
            if (ctrl.mem2mem && chan == 3'h0) begin
              state <= (cur_adr[0][15:8] != upper_addr) ? DRH_S1 : DRH_S2;
            end else begin
              state <= (nxt_adr[15:8] != upper_addr) ? DRH_S1 : DRH_S2;
            end
          end
        end
        default: state <= DRH_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // strobes toward the bus
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_ack_n             <= 8'hff;
      dma_mem_write_n        <= 1'b1;
      dma_mem_write_oe_n     <= 1'b1;
      transfer_count_done    <= 1'b0;
      upper_addr_strobe_byte <= 1'b0;
      upper_addr_strobe_word <= 1'b0;
      upper_addr             <= 8'h00;
      xfer_word              <= 1'b0;
    end else begin
      upper_addr_strobe_byte <= 1'b0;
      upper_addr_strobe_word <= 1'b0;
      transfer_count_done    <= 1'b0;
      // upper byte latch only in S1
      if (state == DRH_S1) begin
        upper_addr <= cur_adr[ech][15:8];
      end
      if (state == DRH_S1) begin
        upper_addr_strobe_byte <= !ech[2];
        upper_addr_strobe_word <= ech[2];
        xfer_word              <= ech[2];
      end
      // acknowledge to the peripheral while the cycle runs
      if (state == DRH_S2 && !swap_ph && !phase) begin
        chan_ack_n <= ~(8'h01 << chan);
      end else if (state == DRH_S4 && (tc_pulse || !keep_on)) begin
        chan_ack_n <= 8'hff;
      end
      // memory write strobe, driven only while the bus is ours
      dma_mem_write_oe_n <= !(grant_s && state != DRH_IDLE &&
                              state != DRH_HOLD);
      if (state == DRH_S2 && (wrmem[ech] || phase)) begin
        dma_mem_write_n <= 1'b0;
      end else if (state == DRH_S4 || state == DRH_IDLE) begin
        dma_mem_write_n <= 1'b1;
      end
      if (state == DRH_S4 && tc_pulse) begin
        transfer_count_done <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite handshake
  // ---------------------------------------------------------------
  assign aw_hs        = s_axi_awvalid && s_axi_awready;
  assign w_hs         = s_axi_wvalid && s_axi_wready;
  assign ar_hs        = s_axi_arvalid && s_axi_arready;
  assign do_wr        = aw_held && w_held && !s_axi_bvalid;
  assign next_aw_held = (aw_held || aw_hs) && !do_wr;
  assign next_w_held  = (w_held || w_hs) && !do_wr;
  assign next_bvalid  = do_wr || (s_axi_bvalid && !s_axi_bready);
  assign next_rvalid  = ar_hs || (s_axi_rvalid && !s_axi_rready);

  // write channels, address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_q          <= 8'h00;
      w_q           <= 32'h0000_0000;
      ws_q          <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DRH_RESP_OKAY;
    end else begin
      if (aw_hs) aw_q <= s_axi_awaddr;
      if (w_hs) begin
        w_q  <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      s_axi_awready <= !next_aw_held && !next_bvalid;
      s_axi_wready  <= !next_w_held && !next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      if (do_wr) begin
        s_axi_bresp <= mapped(aw_q) ? `DRH_RESP_OKAY : `DRH_RESP_SLVERR;
      end
    end
  end

  // read channel, one cycle to the answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DRH_RESP_OKAY;
    end else begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      if (ar_hs) begin
        s_axi_rresp <= mapped(s_axi_araddr) ? `DRH_RESP_OKAY
                                            : `DRH_RESP_SLVERR;
        if (s_axi_araddr == `DRH_OFF_CTRL)
          s_axi_rdata <= {30'h0, ctrl};
        else if (s_axi_araddr == `DRH_OFF_POL)
          s_axi_rdata <= {24'h0, pol};
        else if (s_axi_araddr == `DRH_OFF_MASK)
          s_axi_rdata <= {24'h0, mask};
        else if (s_axi_araddr == `DRH_OFF_SWREQ)
          s_axi_rdata <= {24'h0, swreq};
        else if (s_axi_araddr == `DRH_OFF_MODE)
          s_axi_rdata <= {16'h0, wrmem, autoinit};
        else if (s_axi_araddr == `DRH_OFF_STATUS)
          s_axi_rdata <= {8'h0, bus_hold_request, grant_s, state,
                          ech, pend, tc_stat};
        else if ((s_axi_araddr & `DRH_OFF_ARRMSK) == `DRH_OFF_CNT)
          s_axi_rdata <= {16'h0, cur_cnt[s_axi_araddr[4:2]]};
        else if ((s_axi_araddr & `DRH_OFF_ARRMSK) == `DRH_OFF_ADDR)
          s_axi_rdata <= {16'h0, cur_adr[s_axi_araddr[4:2]]};
        else
          s_axi_rdata <= 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // control registers, mask and status
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    logic [31:0] m;
    m = merge(32'h0, w_q, ws_q);
    if (!aresetn) begin
      ctrl     <= '0;
      pol      <= `DRH_POL_RST;
      mask     <= `DRH_MASK_RST;
      swreq    <= 8'h00;
      autoinit <= 8'h00;
      wrmem    <= 8'h00;
      tc_stat  <= 8'h00;
    end else begin
      if (do_wr && aw_q == `DRH_OFF_CTRL && ws_q[0])
        ctrl <= drh_ctrl_t'(m[1:0]);
      if (do_wr && aw_q == `DRH_OFF_POL && ws_q[0])
        pol <= m[7:0];
      if (do_wr && aw_q == `DRH_OFF_MODE) begin
        if (ws_q[0]) autoinit <= m[7:0];
        if (ws_q[1]) wrmem    <= m[15:8];
      end
      if (do_wr && aw_q == `DRH_OFF_MASK && ws_q[0])
        mask <= m[7:0];
      if (do_wr && aw_q == `DRH_OFF_SWREQ && ws_q[0])
        swreq <= swreq | m[7:0];
      if (do_wr && aw_q == `DRH_OFF_STATUS && ws_q[0])
        tc_stat <= tc_stat & ~m[7:0];
      // service start consumes the software request
      if (state == DRH_HOLD && grant_s)
        swreq[chan] <= 1'b0;
      // terminal count, set beats a same-cycle clear
      if (state == DRH_S4 && tc_pulse) begin
        tc_stat[ech] <= 1'b1;
        if (!autoinit[ech]) mask[ech] <= 1'b1;
      end
    end
  end

  // count and address per channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 8; i++) begin
        base_cnt[i] <= 16'h0000;
        cur_cnt[i]  <= 16'h0000;
        base_adr[i] <= 16'h0000;
        cur_adr[i]  <= 16'h0000;
      end
    end else begin
      if (do_wr && (aw_q & `DRH_OFF_ARRMSK) == `DRH_OFF_CNT) begin
        base_cnt[aw_q[4:2]] <= 16'(merge({16'h0, base_cnt[aw_q[4:2]]},
                                         w_q, ws_q));
        cur_cnt[aw_q[4:2]]  <= 16'(merge({16'h0, base_cnt[aw_q[4:2]]},
                                         w_q, ws_q));
      end
      if (do_wr && (aw_q & `DRH_OFF_ARRMSK) == `DRH_OFF_ADDR) begin
        base_adr[aw_q[4:2]] <= 16'(merge({16'h0, base_adr[aw_q[4:2]]},
                                         w_q, ws_q));
        cur_adr[aw_q[4:2]]  <= 16'(merge({16'h0, base_adr[aw_q[4:2]]},
                                         w_q, ws_q));
      end
      if (state == DRH_S4) begin
        if (at_tc && autoinit[ech]) begin
          cur_cnt[ech] <= base_cnt[ech];
          cur_adr[ech] <= base_adr[ech];
        end else begin
          cur_cnt[ech] <= cur_cnt[ech] - 16'h0001;
          cur_adr[ech] <= nxt_adr;
        end
      end
    end
  end

endmodule : drh_top

`default_nettype wire

// >>> test/drh_top_chk.sv
// assertions on the request, grant and strobe pins of drh_top
`timescale 1ns/100ps
`default_nettype none

module drh_top_chk (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [7:0] chan_ack_n,
  input wire logic       bus_hold_request,
  input wire logic       bus_grant_ack,
  input wire logic       dma_mem_write_n,
  input wire logic       dma_mem_write_oe_n,
  input wire logic       transfer_count_done,
  input wire logic       upper_addr_strobe_byte,
  input wire logic       upper_addr_strobe_word,
  input wire logic [7:0] upper_addr
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // acknowledge only on a bus that was granted
  property p_ack_grant;
    chan_ack_n != 8'hff |-> bus_hold_request && $past(bus_grant_ack, 2);
  endproperty
  a_ack_grant: assert property (p_ack_grant)
    else $error("acknowledge without a synced grant");
  // grant takes two sync stages, so no bus cycle for three edges
  property p_hold_wait;
    $rose(bus_hold_request) |-> dma_mem_write_oe_n [*3];
  endproperty
  a_hold_wait: assert property (p_hold_wait)
    else $error("bus taken before the grant");
  // write strobe low only while the pin is driven
  property p_memw;
    !dma_mem_write_n |-> !dma_mem_write_oe_n && bus_hold_request;
  endproperty
  a_memw: assert property (p_memw)
    else $error("write strobe active while released");
  // terminal count is a single cycle pulse
  property p_tc_pulse;
    transfer_count_done |=> !transfer_count_done;
  endproperty
  a_tc_pulse: assert property (p_tc_pulse)
    else $error("terminal count longer than one cycle");
  // service over when terminal count shows
  property p_tc_ends;
    transfer_count_done |-> chan_ack_n == 8'hff && dma_mem_write_n;
  endproperty
  a_tc_ends: assert property (p_tc_ends)
    else $error("service still running at terminal count");
  // at most one active low acknowledge, cascade channel never
  property p_ack_one;
    $onehot0(~chan_ack_n) && chan_ack_n[4];
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("bad acknowledge pattern");
  // one strobe kind at a time and only as bus owner
  property p_strobe_own;
    upper_addr_strobe_byte || upper_addr_strobe_word |->
      bus_hold_request && !(upper_addr_strobe_byte && upper_addr_strobe_word);
  endproperty
  a_strobe_own: assert property (p_strobe_own)
    else $error("address strobe out of place");
  // upper byte moves only with a strobe
  property p_ua_change;
    !$stable(upper_addr) |-> upper_addr_strobe_byte || upper_addr_strobe_word;
  endproperty
  a_ua_change: assert property (p_ua_change)
    else $error("upper address changed without strobe");
  // hold released only after service has ended
  property p_hold_drop;
    $fell(bus_hold_request) |-> chan_ack_n == 8'hff && dma_mem_write_oe_n;
  endproperty
  a_hold_drop: assert property (p_hold_drop)
    else $error("hold dropped during service");
endmodule : drh_top_chk

bind drh_top drh_top_chk chk_u (
  .aclk, .aresetn, .chan_ack_n, .bus_hold_request, .bus_grant_ack,
  .dma_mem_write_n, .dma_mem_write_oe_n, .transfer_count_done,
  .upper_addr_strobe_byte, .upper_addr_strobe_word, .upper_addr
);

`default_nettype wire

// >>> test/drh_far_model.sv
// far side model: chipset arbiter and requesting peripherals
`timescale 1ns/100ps
`default_nettype none

module drh_far_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] want,
  input  wire logic [7:0] pol,
  input  wire logic [3:0] grant_wait,
  input  wire logic [7:0] chan_ack_n,
  input  wire logic       bus_hold_request,
  output var  logic [7:0] chan_request,
  output var  logic       bus_grant_ack
);
  logic [7:0] act;
  logic [7:0] seen;
  logic [3:0] wait_cnt;

  // idle pins stay inactive, polarity applied on the pin
  assign chan_request = act ^ pol;

  // request held until its acknowledge has been seen
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act  <= 8'h00;
      seen <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (want[i]) begin
          act[i] <= 1'b1;
          if (!chan_ack_n[i]) seen[i] <= 1'b1;
        end else if (seen[i] || !chan_ack_n[i]) begin
          act[i]  <= 1'b0;
          seen[i] <= 1'b0;
        end
      end
    end
  end

  // grant after a delay that stands for the cpu letting go
  always_ff @(posedge aclk) begin
    if (!aresetn || !bus_hold_request) begin
      wait_cnt      <= 4'h0;
      bus_grant_ack <= 1'b0;
    end else if (wait_cnt != grant_wait) begin
      wait_cnt <= wait_cnt + 4'h1;
    end else begin
      bus_grant_ack <= 1'b1;
    end
  end
endmodule : drh_far_model

`default_nettype wire

// >>> test/drh_top_test.sv
// self-checking bench for drh_top with the far side model
`timescale 1ns/100ps
`default_nettype none
`include "drh_params.svh"

module drh_top_test;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp;
  logic [7:0]  chan_request, chan_ack_n, upper_addr;
  logic [7:0]  want = 8'h00, pol = 8'h00, ack_prev = 8'hff;
  logic [3:0]  grant_wait = 4'h0;
  logic        bus_hold_request, bus_grant_ack, dma_mem_write_n;
  logic        dma_mem_write_oe_n, transfer_count_done, xfer_word;
  logic        upper_addr_strobe_byte, upper_addr_strobe_word;
  logic        mw_prev = 1'b1;
  logic [15:0] ack_hist = 16'h0;
  logic [31:0] d;
  int          errors = 0, checks = 0;
  int          n_tc = 0, n_sb = 0, n_sw = 0, n_mw = 0, n_ack = 0;

  always #50 aclk = ~aclk;

  drh_top dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .chan_request, .chan_ack_n, .bus_hold_request,
    .bus_grant_ack, .dma_mem_write_n, .dma_mem_write_oe_n,
    .transfer_count_done, .upper_addr_strobe_byte, .upper_addr_strobe_word,
    .upper_addr, .xfer_word
  );

  drh_far_model far_u (
    .aclk, .aresetn, .want, .pol, .grant_wait, .chan_ack_n,
    .bus_hold_request, .chan_request, .bus_grant_ack
  );

  // event counters on the device side pins
  always @(posedge aclk) begin
    ack_prev <= chan_ack_n;
    mw_prev  <= dma_mem_write_n;
    if (transfer_count_done === 1'b1) n_tc++;
    if (upper_addr_strobe_byte === 1'b1) n_sb++;
    if (upper_addr_strobe_word === 1'b1) n_sw++;
    if (mw_prev === 1'b1 && dma_mem_write_n === 1'b0) n_mw++;
    if (ack_prev === 8'hff && chan_ack_n !== 8'hff) begin
      n_ack++;
      ack_hist <= {ack_hist[7:0], ~chan_ack_n};
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one axi4-lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    last_resp = s_axi_bresp;
  endtask : wr

  // one axi4-lite read, data taken at the rvalid edge
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    last_resp = s_axi_rresp;
  endtask : rd

  task automatic pulse(input logic [7:0] m);
    want <= m;
    @(posedge aclk);
    want <= 8'h00;
  endtask : pulse

  // wait for the bus to be handed back
  task automatic settle();
    repeat (12) @(posedge aclk);
    while (bus_hold_request !== 1'b0) @(posedge aclk);
    repeat (4) @(posedge aclk);
  endtask : settle

  task automatic t_reset();
    rd(`DRH_OFF_MASK, d);
    chk(d, 32'hff);
    rd(`DRH_OFF_POL, d);
    chk(d, 32'h0);
    chk({23'h0, bus_hold_request, chan_ack_n}, 32'hff);
    chk(32'(dma_mem_write_oe_n), 32'h1);
    rd(8'hfc, d);
    chk({d[29:0], last_resp}, {30'h0, `DRH_RESP_SLVERR});
    wr(8'hfc, 32'h0);
    chk({30'h0, last_resp}, {30'h0, `DRH_RESP_SLVERR});
  endtask : t_reset

  task automatic t_runoff();
    int a0, w0;
    a0 = n_ack;
    w0 = n_sw;
    pol <= 8'h40;
    wr(`DRH_OFF_POL, 32'h40);
    wr(`DRH_OFF_MASK, 32'hbf);
    pulse(8'h40);
    repeat (20) @(posedge aclk);
    chk(32'(bus_hold_request), 32'h0);
    wr(`DRH_OFF_CTRL, 32'h1);
    settle();
    chk(32'(n_ack - a0), 32'h1);
    chk(32'(ack_hist[7:0]), 32'h40);
    chk(32'(xfer_word), 32'h1);
    chk(32'(n_sw - w0), 32'h1);
    pulse(8'h80);
    repeat (20) @(posedge aclk);
    chk(32'(bus_hold_request), 32'h0);
  endtask : t_runoff

  task automatic t_demand();
    int t0, b0, m0;
    t0 = n_tc;
    b0 = n_sb;
    m0 = n_mw;
    grant_wait <= 4'h5;
    wr(`DRH_OFF_ADDR + 8'h08, 32'h1fe);
    wr(`DRH_OFF_CNT + 8'h08, 32'h2);
    wr(`DRH_OFF_MODE, 32'h400);
    wr(`DRH_OFF_MASK, 32'hfb);
    want <= 8'h04;
    while (n_tc == t0) @(posedge aclk);
    want <= 8'h00;
    settle();
    chk(32'(n_tc - t0), 32'h1);
    chk(32'(n_sb - b0), 32'h2);
    chk(32'(upper_addr), 32'h02);
    chk(32'(n_mw - m0), 32'h3);
    chk(32'(xfer_word), 32'h0);
    chk(32'(bus_hold_request), 32'h0);
    rd(`DRH_OFF_MASK, d);
    chk(d, 32'hff);
    rd(`DRH_OFF_STATUS, d);
    chk(d & 32'hff, 32'h44);
    wr(`DRH_OFF_STATUS, 32'hff);
  endtask : t_demand

  task automatic t_prio();
    int w0, b0;
    w0 = n_sw;
    b0 = n_sb;
    grant_wait <= 4'h0;
    wr(`DRH_OFF_ADDR + 8'h14, 32'h1234);
    wr(`DRH_OFF_ADDR + 8'h04, 32'h10);
    wr(`DRH_OFF_MASK, 32'hdd);
    pulse(8'h22);
    settle();
    chk(32'(ack_hist), 32'h0220);
    chk(32'(upper_addr), 32'h12);
    chk(32'(xfer_word), 32'h1);
    chk(32'(n_sw - w0), 32'h1);
    chk(32'(n_sb - b0), 32'h1);
  endtask : t_prio

  task automatic t_auto();
    wr(`DRH_OFF_MODE, 32'h808);
    wr(`DRH_OFF_ADDR + 8'h0c, 32'hff);
    wr(`DRH_OFF_MASK, 32'hf7);
    pulse(8'h08);
    settle();
    rd(`DRH_OFF_ADDR + 8'h0c, d);
    chk(d, 32'hff);
    rd(`DRH_OFF_MASK, d);
    chk(d, 32'hf7);
    rd(`DRH_OFF_STATUS, d);
    chk(d & 32'hff, 32'h2a);
  endtask : t_auto

  task automatic t_copy();
    int t0, a0, m0;
    t0 = n_tc;
    a0 = n_ack;
    m0 = n_mw;
    wr(`DRH_OFF_STATUS, 32'hff);
    wr(`DRH_OFF_MODE, 32'h0);
    wr(`DRH_OFF_CNT + 8'h04, 32'h0);
    wr(`DRH_OFF_MASK, 32'hfc);
    wr(`DRH_OFF_CTRL, 32'h3);
    wr(`DRH_OFF_SWREQ, 32'h1);
    settle();
    chk(32'(n_tc - t0), 32'h1);
    chk(32'(n_ack - a0), 32'h0);
    chk(32'(n_mw - m0), 32'h1);
    rd(`DRH_OFF_STATUS, d);
    chk(32'(d[1]), 32'h1);
  endtask : t_copy

  task automatic report_and_stop();
    if (errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_runoff();
    t_demand();
    t_prio();
    t_auto();
    t_copy();
    report_and_stop();
  end

  // watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    report_and_stop();
  end
endmodule : drh_top_test

`default_nettype wire
